// ==== common/bbseq_cfg.svh ====
// Purpose: Constants for the buck-boost phase sequencer
// Assumes: 200 MHz clock_i, 5 ns period
// Notes:   Offsets are register addresses on the configuration port
`ifndef BBSEQ_CFG_SVH
`define BBSEQ_CFG_SVH
`define CLK_PERIOD_NS        5
`define REG_MODE_CFG         8'h01
`define REG_PEAK_LIMITS      8'h03
`define REG_LOOP_CFG         8'h04
`define MODE_SEL_BIT         2
`define ZC_DIS_BIT           4
`define ADAPT_DIS_BIT        1
`define INTEG_EN_BIT         2
`define MODE_CFG_RST         8'h00
`define PEAK_LIMITS_RST      8'h44
`define LOOP_CFG_RST         8'h04
`define CHARGE_TIMEOUT_NS    500
`define CHARGE_TIMEOUT_CYC   (`CHARGE_TIMEOUT_NS / `CLK_PERIOD_NS)
`define FREEWHEEL_NS         30
`define FREEWHEEL_CYC        (`FREEWHEEL_NS / `CLK_PERIOD_NS)
`endif

// ==== common/bbseq_pkg.sv ====
// Purpose: Types for the buck-boost phase sequencer
// Assumes: Nothing
// Notes:   One-hot phase codes
package bbseq_pkg;
	typedef enum logic [4:0] {
		PH_IDLE = 5'h01,
		PH_1    = 5'h02,
		PH_2    = 5'h04,
		PH_3    = 5'h08,
		PH_4    = 5'h10
	} phase_t;
endpackage

// ==== logic/sync2.sv ====
// Purpose: Two-flop synchroniser for a vector of comparator levels
// Assumes: Inputs asynchronous to clock_i
// Notes:   First stage is read only by the second
module sync2 #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clock_i,
	input  wire logic         rstn_i,
	// Data
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	logic [W-1:0] meta_q;
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			meta_q <= '0;
			sync_o <= '0;
		end else begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end
endmodule

// ==== logic/buck_boost_phase_sequencer.sv ====
// Purpose: Selects the two conducting power switches in each switching phase
// Assumes: Comparators compare inductor current with the limit codes driven out here
// Notes:   Analog loop is external; only its integrator and limit codes come from here
//
// Overview of operation
// [R1] Each phase turns on exactly two switches; phase 4 freewheels on both lows.
// [R2] Mode bit 0x01[2] low selects buck-boost, high selects buck-only sequencing.
// [R3] Buck-boost charges in phase 2 up to primary peak, then goes phase 1.
// [R4] Phase 1 with Vin above Vout ends at primary plus secondary peak or timeout.
// [R5] Phase 1 with Vin at or below Vout ends at valley or timeout.
// [R6] Charge timeout starts when current reaches the primary peak limit, or at phase 1 entry in buck-only.
// [R7] Phase 3 discharges to valley or below zero, then freewheels in phase 4.
// [R8] CCM with zero comparator disabled passes phase 4 for about 30 ns.
// [R9] CCM with zero comparator enabled skips phase 4 straight to charging.
// [R10] Buck-only never uses phase 2; phase 1 ends at peak or timeout.
// [R11] Adaptive disable holds programmed peaks and forces valley limit to zero.
// [R12] Adaptive enabled lets the adaptive control move peak and valley limits.
// [R13] Startup forces DCM, zero valley and soft-start peak limits.
// [R14] Zero comparator disabled: valley limit doubles as zero-crossing threshold.
// [R15] Zero comparator enabled: zero threshold fixed 0 mA, phase 4 on crossing.
// [R16] Bit 0x04[2] switches loop between proportional and integrator operation.
// [R17] Integrator bit one means integrator on, zero means proportional only.
// [R18] Auxiliary input n-switch enabled only while input is below falling UVLO.
// [R19] Comparators are synchronised; timeout counter clears on every restart.
`include "bbseq_cfg.svh"
module buck_boost_phase_sequencer
	import bbseq_pkg::*;
(
	// Clock and reset
	input  wire logic       clock_i,
	input  wire logic       rstn_i,
	// Configuration port
	input  wire logic       cfg_wr_i,
	input  wire logic [7:0] cfg_addr_i,
	input  wire logic [7:0] cfg_wdata_i,
	output logic      [7:0] cfg_rdata_o,
	// Regulator control
	input  wire logic       enable_i,
	input  wire logic       startup_done_i,
	input  wire logic       ccm_allowed_i,
	input  wire logic [3:0] adapt_primary_i,
	input  wire logic [3:0] adapt_secondary_i,
	input  wire logic [3:0] adapt_valley_i,
	input  wire logic [3:0] softstart_primary_peak_i,
	input  wire logic [3:0] softstart_secondary_peak_i,
	// Analog comparators (asynchronous)
	input  wire logic       peak_primary_cmp_i,
	input  wire logic       peak_total_cmp_i,
	input  wire logic       valley_cmp_i,
	input  wire logic       zero_cross_cmp_i,
	input  wire logic       vin_above_vout_cmp_i,
	input  wire logic       vin_below_uvlo_cmp_i,
	// Gate drive and limit codes
	output logic            input_high_switch_o,
	output logic            input_low_switch_o,
	output logic            output_high_switch_o,
	output logic            output_low_switch_o,
	output logic            input_aux_nswitch_o,
	output logic      [3:0] primary_limit_o,
	output logic      [3:0] total_extra_limit_o,
	output logic      [3:0] valley_limit_o,
	output logic            zero_cmp_enable_o,
	output logic            loop_integrator_enable_o,
	output logic [4:0]      phase_o
);
	localparam logic [6:0] TMO_CYC = 7'(`CHARGE_TIMEOUT_CYC);
	localparam logic [6:0] FW_CYC  = 7'(`FREEWHEEL_CYC);
	logic [7:0] mode_cfg_q, inductor_peak_limits_q, loop_cfg_q;
	logic [5:0] cmp_s;
	logic       pk1, pktot, valley, zc, vin_gt, uvlo;
	phase_t     phase_q, phase_d;
	logic [6:0] tmo_cnt_q, fw_cnt_q;
	logic       tmo_run_q, tmo_done, startup_q;
	logic       buck_only, zc_dis, adapt_dis, ccm, discharge_end;

	// Comparators cross in one shared synchroniser [R19]
	sync2 #(.W(6)) u_cmp_sync (
		.clock_i (clock_i),
		.rstn_i  (rstn_i),
		.async_i ({peak_primary_cmp_i, peak_total_cmp_i, valley_cmp_i,
		           zero_cross_cmp_i, vin_above_vout_cmp_i, vin_below_uvlo_cmp_i}),
		.sync_o  (cmp_s)
	);
	assign {pk1, pktot, valley, zc, vin_gt, uvlo} = cmp_s;

	// Register file
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mode_cfg_q             <= `MODE_CFG_RST;
			inductor_peak_limits_q <= `PEAK_LIMITS_RST;
			loop_cfg_q             <= `LOOP_CFG_RST;
		end else if (cfg_wr_i) begin
			unique case (cfg_addr_i)
				`REG_MODE_CFG:    mode_cfg_q             <= cfg_wdata_i;
				`REG_PEAK_LIMITS: inductor_peak_limits_q <= cfg_wdata_i;
				`REG_LOOP_CFG:    loop_cfg_q             <= cfg_wdata_i;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cfg_rdata_o <= 8'h00;
		end else begin
			unique case (cfg_addr_i)
				`REG_MODE_CFG:    cfg_rdata_o <= mode_cfg_q;
				`REG_PEAK_LIMITS: cfg_rdata_o <= inductor_peak_limits_q;
				`REG_LOOP_CFG:    cfg_rdata_o <= loop_cfg_q;
				default:          cfg_rdata_o <= 8'h00;
			endcase
		end
	end

	assign buck_only = mode_cfg_q[`MODE_SEL_BIT];   // [R2]
	assign zc_dis    = mode_cfg_q[`ZC_DIS_BIT];
	assign adapt_dis = loop_cfg_q[`ADAPT_DIS_BIT];

	// Startup latch: set again on disable, released once output is final
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			startup_q <= 1'b1;
		end else if (!enable_i) begin
			startup_q <= 1'b1;
		end else if (startup_done_i) begin
			startup_q <= 1'b0;
		end
	end

	// CCM only after startup [R13]
	assign ccm = ccm_allowed_i && !startup_q;

	// Limit codes to the comparator DACs
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			primary_limit_o     <= 4'h0;
			total_extra_limit_o <= 4'h0;
			valley_limit_o      <= 4'h0;
			zero_cmp_enable_o   <= 1'b0;
		end else begin
			zero_cmp_enable_o <= !zc_dis;   // [R14] [R15]
			if (startup_q) begin
				primary_limit_o     <= softstart_primary_peak_i;   // [R13]
				total_extra_limit_o <= softstart_secondary_peak_i;
				valley_limit_o      <= 4'h0;
			end else if (adapt_dis) begin
				primary_limit_o     <= inductor_peak_limits_q[3:0];   // [R11]
				total_extra_limit_o <= inductor_peak_limits_q[7:4];
				valley_limit_o      <= 4'h0;
			end else begin
				primary_limit_o     <= adapt_primary_i;   // [R12]
				total_extra_limit_o <= adapt_secondary_i;
				valley_limit_o      <= adapt_valley_i;
			end
		end
	end

	// Integrator bit passed to the analog loop [R16] [R17]
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			loop_integrator_enable_o <= 1'b1;
		end else begin
			loop_integrator_enable_o <= loop_cfg_q[`INTEG_EN_BIT];
		end
	end

	// Aux n-switch only under UVLO, and only when input high side conducts [R18]
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			input_aux_nswitch_o <= 1'b0;
		end else begin
			input_aux_nswitch_o <= uvlo && (phase_d == PH_1 || phase_d == PH_2);
		end
	end

	// Charge timeout, restarted from zero at primary peak, or at phase 1 entry in buck-only [R6] [R19]
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tmo_cnt_q <= 7'h00;
			tmo_run_q <= 1'b0;
		end else if (phase_q != PH_1 && phase_d == PH_1 && (pk1 || buck_only)) begin
			tmo_cnt_q <= 7'h00;
			tmo_run_q <= 1'b1;
		end else if (phase_q == PH_1 && !tmo_run_q && pk1) begin
			tmo_cnt_q <= 7'h00;
			tmo_run_q <= 1'b1;
		end else if (phase_q != PH_1) begin
			tmo_run_q <= 1'b0;
		end else if (tmo_run_q && !tmo_done) begin
			tmo_cnt_q <= tmo_cnt_q + 7'h01;
		end
	end
	assign tmo_done = tmo_run_q && (tmo_cnt_q >= TMO_CYC - 7'h01);

	// Short freewheel counter for CCM with zero comparator off [R8]
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			fw_cnt_q <= 7'h00;
		end else if (phase_q != PH_4) begin
			fw_cnt_q <= 7'h00;
		end else if (fw_cnt_q != FW_CYC) begin
			fw_cnt_q <= fw_cnt_q + 7'h01;
		end
	end

	// Discharge ends at valley, or at zero crossing when the comparator is on
	assign discharge_end = valley || (!zc_dis && zc);   // [R7] [R14]

	// Phase sequencing
	always_comb begin
		phase_d = phase_q;
		unique case (phase_q)
			PH_IDLE: begin
				if (enable_i) begin
					phase_d = buck_only ? PH_1 : PH_2;
				end
			end
			PH_2: begin
				if (pk1) begin
					phase_d = PH_1;   // [R3]
				end
			end
			PH_1: begin
				if (buck_only) begin
					if (pk1 || tmo_done) begin
						phase_d = PH_3;   // [R10]
					end
				end else if (vin_gt) begin
					if (pktot || tmo_done) begin
						phase_d = PH_3;   // [R4]
					end
				end else if (valley || tmo_done) begin
					phase_d = PH_3;   // [R5]
				end
			end
			PH_3: begin
				if (discharge_end) begin
					if (ccm && !zc_dis && !zc) begin
						phase_d = buck_only ? PH_1 : PH_2;   // [R9]
					end else begin
						phase_d = PH_4;   // [R7]
					end
				end
			end
			PH_4: begin
				if (ccm && zc_dis) begin
					if (fw_cnt_q == FW_CYC - 7'h01) begin
						phase_d = buck_only ? PH_1 : PH_2;   // [R8]
					end
				end else begin
					// No load-demand input: waiting on valley could stall at zero current
					phase_d = buck_only ? PH_1 : PH_2;   // [R7] [R15]
				end
			end
			default: phase_d = PH_IDLE;
		endcase
		if (!enable_i) begin
			phase_d = PH_IDLE;
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			phase_q <= PH_IDLE;
		end else begin
			phase_q <= phase_d;
		end
	end

	// Two switches per phase, registered straight from next phase [R1]
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			input_high_switch_o  <= 1'b0;
			input_low_switch_o   <= 1'b0;
			output_high_switch_o <= 1'b0;
			output_low_switch_o  <= 1'b0;
			phase_o              <= 5'h01;
		end else begin
			input_high_switch_o  <= (phase_d == PH_1) || (phase_d == PH_2);
			input_low_switch_o   <= (phase_d == PH_3) || (phase_d == PH_4);
			output_high_switch_o <= (phase_d == PH_1) || (phase_d == PH_3);
			output_low_switch_o  <= (phase_d == PH_2) || (phase_d == PH_4);
			phase_o              <= phase_d;
		end
	end

	property p_two_switches;
		@(posedge clock_i) disable iff (!rstn_i)
		(phase_o != 5'h01) |-> ($countones({input_high_switch_o, input_low_switch_o,
			output_high_switch_o, output_low_switch_o}) == 2);
	endproperty
	a_two_switches: assert property (p_two_switches) else $error("not two switches"); // [R1]
	property p_buck_no_ph2;
		@(posedge clock_i) disable iff (!rstn_i)
		(buck_only && phase_q != PH_2) |=> (phase_q != PH_2);
	endproperty
	a_buck_no_ph2: assert property (p_buck_no_ph2) else $error("phase 2 in buck"); // [R10]
	property p_ph2_to_ph1;
		@(posedge clock_i) disable iff (!rstn_i)
		(phase_q == PH_2 && pk1 && enable_i) |=> (phase_q == PH_1);
	endproperty
	a_ph2_to_ph1: assert property (p_ph2_to_ph1) else $error("phase 2 exit wrong"); // [R3]
	property p_timeout;
		@(posedge clock_i) disable iff (!rstn_i)
		(phase_q == PH_1 && tmo_run_q && tmo_cnt_q == 7'h00 && enable_i) |->
			##[1:100] (phase_q != PH_1);
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout exceeded"); // [R6]
	property p_fw_len;
		@(posedge clock_i) disable iff (!rstn_i)
		($rose(phase_q == PH_4) && ccm && zc_dis && enable_i) |->
			(phase_q == PH_4) [*6];
	endproperty
	a_fw_len: assert property (p_fw_len) else $error("short freewheel"); // [R8]
	property p_valley_zero;
		@(posedge clock_i) disable iff (!rstn_i)
		(adapt_dis || startup_q) |=> (valley_limit_o == 4'h0);
	endproperty
	a_valley_zero: assert property (p_valley_zero) else $error("valley not zero"); // [R11]
	property p_aux;
		@(posedge clock_i) disable iff (!rstn_i)
		input_aux_nswitch_o |-> $past(uvlo);
	endproperty
	a_aux: assert property (p_aux) else $error("aux switch without uvlo"); // [R18]
	property p_integ;
		@(posedge clock_i) disable iff (!rstn_i)
		(cfg_wr_i && cfg_addr_i == `REG_LOOP_CFG) |->
			##2 (loop_integrator_enable_o == $past(cfg_wdata_i[`INTEG_EN_BIT], 2));
	endproperty
	a_integ: assert property (p_integ) else $error("integrator bit wrong"); // [R17]
	property p_ccm_skip;
		@(posedge clock_i) disable iff (!rstn_i)
		(phase_q == PH_3 && valley && ccm && !zc_dis && !zc && enable_i) |=>
			(phase_q != PH_4);
	endproperty
	a_ccm_skip: assert property (p_ccm_skip) else $error("phase 4 not skipped"); // [R9]
endmodule

// ==== verif/inductor_model.sv ====
// Purpose: Behavioural inductor and current comparators facing the sequencer
// Assumes: One current step per clock in phase 1, two in phases 2 and 3, eight steps per limit code
// Notes:   Current clamps at zero in phase 3, as a blocked low-side would in DCM
module inductor_model (
	// Clock
	input  wire logic       clock_i,
	// Gate enables and limit codes
	input  wire logic       in_hi_i,
	input  wire logic       in_lo_i,
	input  wire logic       out_hi_i,
	input  wire logic       out_lo_i,
	input  wire logic [3:0] primary_i,
	input  wire logic [3:0] extra_i,
	input  wire logic [3:0] valley_i,
	// Conditions set by the bench
	input  wire logic       vin_above_i,
	input  wire logic       hold_i,
	// Comparator levels
	output logic            peak_primary_o,
	output logic            peak_total_o,
	output logic            valley_o,
	output logic            zero_o
);
	timeunit 1ns;
	timeprecision 100ps;
	int cur = 0;
	// Hold freezes the phase 1 ramp so only the timeout can end it
	always @(posedge clock_i) begin
		if (in_hi_i && out_lo_i)
			cur <= cur + 2;
		else if (in_hi_i && out_hi_i && !hold_i)
			cur <= vin_above_i ? cur + 1 : cur - 1;
		else if (in_lo_i && out_hi_i)
			cur <= (cur > 2) ? cur - 2 : 0;
	end
	assign peak_primary_o = cur >= 8 * int'(primary_i);
	assign peak_total_o   = cur >= 8 * (int'(primary_i) + int'(extra_i));
	// At or below the code, so a zero code trips at zero current
	assign valley_o       = cur <= 8 * int'(valley_i);
	assign zero_o         = cur <= 0;
endmodule

// ==== verif/buck_boost_phase_sequencer_tb_top.sv ====
// Purpose: Self-checking bench for the buck-boost phase sequencer
// Assumes: Inductor model on the far side, inputs driven 1 ns after the edge
// Notes:   Phase timing judged from run lengths seen at phase_o
module buck_boost_phase_sequencer_tb_top
	import bbseq_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock_i = 0, rstn_i = 0, cfg_wr_i = 0, enable_i = 0;
	logic startup_done_i = 0, ccm_allowed_i = 0, hold = 0, clr = 0;
	logic vin_above_vout_cmp_i = 1, vin_below_uvlo_cmp_i = 0;
	logic [7:0] cfg_addr_i = 0, cfg_wdata_i = 0, cfg_rdata_o;
	logic [3:0] adapt_primary_i = 4'h8, adapt_secondary_i = 4'h4, adapt_valley_i = 4'h4;
	logic [3:0] softstart_primary_peak_i = 4'h2, softstart_secondary_peak_i = 4'h1;
	logic peak_primary_cmp_i, peak_total_cmp_i, valley_cmp_i, zero_cross_cmp_i;
	logic input_high_switch_o, input_low_switch_o, output_high_switch_o;
	logic output_low_switch_o, input_aux_nswitch_o, zero_cmp_enable_o;
	logic loop_integrator_enable_o;
	logic [3:0] primary_limit_o, total_extra_limit_o, valley_limit_o;
	logic [4:0] phase_o, seen;
	logic [2:0] ons;
	int run1 = 0, run4 = 0, max1, max4, auxn, cyc = 0, bad_count = 0, compares = 0;
	typedef struct {logic [7:0] a, d, e; logic wr, zc, ig;} row_t;
	row_t rows[9] = '{
		'{8'h01, 8'h00, 8'h00, 0, 1, 1}, '{8'h03, 8'h00, 8'h44, 0, 1, 1},
		'{8'h04, 8'h00, 8'h04, 0, 1, 1}, '{8'h02, 8'h55, 8'h00, 1, 1, 1},
		'{8'h03, 8'hA5, 8'hA5, 1, 1, 1}, '{8'h01, 8'h14, 8'h14, 1, 0, 1},
		'{8'h01, 8'h00, 8'h00, 1, 1, 1}, '{8'h04, 8'h00, 8'h00, 1, 1, 0},
		'{8'h04, 8'h04, 8'h04, 1, 1, 1}};

	buck_boost_phase_sequencer dut (.clock_i, .rstn_i, .cfg_wr_i, .cfg_addr_i,
		.cfg_wdata_i, .cfg_rdata_o, .enable_i, .startup_done_i, .ccm_allowed_i,
		.adapt_primary_i, .adapt_secondary_i, .adapt_valley_i,
		.softstart_primary_peak_i, .softstart_secondary_peak_i, .peak_primary_cmp_i,
		.peak_total_cmp_i, .valley_cmp_i, .zero_cross_cmp_i, .vin_above_vout_cmp_i,
		.vin_below_uvlo_cmp_i, .input_high_switch_o, .input_low_switch_o,
		.output_high_switch_o, .output_low_switch_o, .input_aux_nswitch_o,
		.primary_limit_o, .total_extra_limit_o, .valley_limit_o, .zero_cmp_enable_o,
		.loop_integrator_enable_o, .phase_o);

	inductor_model coil (.clock_i, .in_hi_i(input_high_switch_o),
		.in_lo_i(input_low_switch_o), .out_hi_i(output_high_switch_o),
		.out_lo_i(output_low_switch_o), .primary_i(primary_limit_o),
		.extra_i(total_extra_limit_o), .valley_i(valley_limit_o),
		.vin_above_i(vin_above_vout_cmp_i), .hold_i(hold),
		.peak_primary_o(peak_primary_cmp_i), .peak_total_o(peak_total_cmp_i),
		.valley_o(valley_cmp_i), .zero_o(zero_cross_cmp_i));

	always #2.5 clock_i = ~clock_i;

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		cfg_addr_i = a;
		cfg_wdata_i = d;
		cfg_wr_i = 1;
		tick(1);
		cfg_wr_i = 0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		cfg_addr_i = a;
		tick(2);
		check(cfg_rdata_o, e);
	endtask

	task automatic measure(input int n);
		clr = 1;
		tick(1);
		clr = 0;
		tick(n);
	endtask

	task automatic lims(input logic [3:0] p, input logic [3:0] s, input logic [3:0] v);
		check(primary_limit_o, p);
		check(total_extra_limit_o, s);
		check(valley_limit_o, v);
	endtask

	// Hang guard; the whole run needs under 5000 cycles
	always @(posedge clock_i)
		if (++cyc == 20000) begin
			bad_count++;
			report_and_stop();
		end

	always @(posedge clock_i) begin
		ons = 3'(input_high_switch_o) + 3'(input_low_switch_o)
			+ 3'(output_high_switch_o) + 3'(output_low_switch_o);
		if (rstn_i) begin
			check(ons == 0 || ons == 2, 1);
			check(!input_aux_nswitch_o || input_high_switch_o, 1);
		end
		run1 = (phase_o == PH_1) ? run1 + 1 : 0;
		run4 = (phase_o == PH_4) ? run4 + 1 : 0;
		if (clr) begin
			seen = 0;
			max1 = 0;
			max4 = 0;
			auxn = 0;
		end
		seen |= phase_o;
		max1 = (run1 > max1) ? run1 : max1;
		max4 = (run4 > max4) ? run4 : max4;
		auxn += int'(input_aux_nswitch_o);
	end

	initial begin
		repeat (20) @(posedge clock_i);
		#1 rstn_i = 1;
		foreach (rows[k]) begin
			if (rows[k].wr)
				wr(rows[k].a, rows[k].d);
			rd(rows[k].a, rows[k].e);
			check(zero_cmp_enable_o, rows[k].zc);
			check(loop_integrator_enable_o, rows[k].ig);
		end
		wr(8'h03, 8'h36);
		enable_i = 1;
		measure(300);
		lims(4'h2, 4'h1, 4'h0);
		check(seen[2], 1);
		check(seen[1] & seen[3] & seen[4], 1);
		startup_done_i = 1;
		ccm_allowed_i = 1;
		tick(20);
		lims(4'h8, 4'h4, 4'h4);
		measure(400);
		check(seen[4], 0);
		wr(8'h01, 8'h10);
		measure(400);
		check(max4 inside {[5:7]}, 1);
		wr(8'h04, 8'h06);
		tick(4);
		lims(4'h6, 4'h3, 4'h0);
		wr(8'h04, 8'h04);
		vin_above_vout_cmp_i = 0;
		measure(400);
		check(seen[1] && max1 < 60, 1);
		vin_above_vout_cmp_i = 1;
		hold = 1;
		measure(400);
		check(max1 inside {[95:106]}, 1);
		hold = 0;
		wr(8'h01, 8'h14);
		tick(40);
		measure(400);
		check(seen[2], 0);
		check(seen[1] & seen[3], 1);
		vin_below_uvlo_cmp_i = 1;
		measure(200);
		check(auxn > 0, 1);
		vin_below_uvlo_cmp_i = 0;
		tick(5);
		measure(200);
		check(auxn == 0, 1);
		enable_i = 0;
		tick(6);
		check(phase_o, PH_IDLE);
		check(ons, 0);
		lims(4'h2, 4'h1, 4'h0);
		rstn_i = 0;
		tick(2);
		rstn_i = 1;
		rd(8'h03, 8'h44);
		report_and_stop();
	end
endmodule
